// ===== rtl/rfh_header_status.sv
// Receive frame header status and byte count registers for the frame at the queue head.
// Assumes the receive engine reports each finished frame with one end pulse, and the
// queue manager pulses frameRelease when the host has finished with the head frame.
`timescale 1ns/1ps
module rfh_header_status
	import rfh_pkg::*;
#(
	parameter int QUEUE_DEPTH = 8,
	parameter int QUEUE_PTR_W = 3
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic rxEnd,
	input wire logic [RFH_ADDR_W-1:0] rxDestAddr,
	input wire logic [15:0] rxLenType,
	input wire logic [RFH_COUNT_W-1:0] rxByteCount,
	input wire logic rxSymbolErr,
	input wire logic rxCollision,
	input wire logic rxEarlyEnd,
	input wire logic rxCrcBad,
	input wire logic rxIcmpBad,
	input wire logic rxIpBad,
	input wire logic rxTcpBad,
	input wire logic rxUdpBad,
	input wire logic passBadFrame,
	input wire logic frameRelease,
	input wire logic hostByteMode,
	input wire logic hostRd,
	input wire logic [7:0] hostAddr,
	output logic [15:0] hostRdData,
	output logic hostRdValid,
	output logic frameValid,
	output logic [QUEUE_PTR_W:0] framesQueued,
	output logic frameDropped,
	output logic queueOverflow
);
	// ----------------------------------------------------------------
	// Frame classification
	// ----------------------------------------------------------------

	// True when the destination is the all-ones broadcast address.
	function automatic logic isBroadcast(input logic [RFH_ADDR_W-1:0] addr);
		return addr == RFH_BCAST_ADDR;
	endfunction : isBroadcast

	// Selects one byte of a register word for the 8-bit bus.
	function automatic logic [7:0] pickByte(input logic [15:0] word, input logic hi);
		return hi ? word[15:8] : word[7:0];
	endfunction : pickByte

	logic groupAddr;
	logic bcastAddr;
	logic ethType;
	logic oversize;
	logic runt;
	logic badFrame;
	logic acceptFrame;
	logic [RFH_REG_W-1:0] newStatus;

	// The group bit is the first bit on the wire, held in the low bit of the first byte.
	assign groupAddr = rxDestAddr[RFH_GROUP_BIT];
	assign bcastAddr = isBroadcast(rxDestAddr);
	assign ethType = rxLenType > RFH_LEN_TYPE_MAX;
	assign oversize = rxByteCount > RFH_OVERSIZE_MAX;
	assign runt = rxCollision || rxEarlyEnd;

	// Bad frames go to the host only while the pass setting is on.
	assign badFrame = oversize || runt || rxCrcBad;
	assign acceptFrame = !badFrame || passBadFrame;

	// Status word as stored; the valid bit is added live at read time.
	always_comb begin
		newStatus = RFH_ZERO16;
		newStatus[RFH_B_ICMP] = rxIcmpBad;
		newStatus[RFH_B_IP] = rxIpBad;
		newStatus[RFH_B_TCP] = rxTcpBad;
		newStatus[RFH_B_UDP] = rxUdpBad;
		newStatus[RFH_B_BCAST] = bcastAddr;
		newStatus[RFH_B_MCAST] = groupAddr || bcastAddr;
		newStatus[RFH_B_UCAST] = !groupAddr && !bcastAddr;
		newStatus[RFH_B_SYMERR] = rxSymbolErr;
		newStatus[RFH_B_ETHTYPE] = ethType;
		newStatus[RFH_B_OVERSIZE] = oversize;
		newStatus[RFH_B_RUNT] = runt;
		newStatus[RFH_B_CRC] = rxCrcBad;
	end

	// ----------------------------------------------------------------
	// Status queue
	// ----------------------------------------------------------------
	rfh_queue_if #(
		.WIDTH(RFH_ENTRY_W),
		.LEVEL_W(QUEUE_PTR_W + 1)
	) statusQ ();

	rfh_status_queue #(
		.DEPTH(QUEUE_DEPTH),
		.PTR_W(QUEUE_PTR_W)
	) u_queue (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.q(statusQ)
	);

	// Status and count travel as one entry, so they can never describe two frames.
	// The byte count is stored exactly as received, oversize or not.
	assign statusQ.push = rxEnd && acceptFrame && !statusQ.full;
	assign statusQ.pushData = {rxByteCount, newStatus};
	assign statusQ.pop = frameRelease && !statusQ.empty;

	// ----------------------------------------------------------------
	// Head frame view
	// ----------------------------------------------------------------
	logic [RFH_REG_W-1:0] headStatus;
	logic [RFH_REG_W-1:0] headCount;
	logic headValid;

	// A frame still arriving is not in the queue yet, so an empty queue reads invalid.
	assign headValid = !statusQ.empty;

	// Valid bit overlays the stored word; reserved bits stay zero.
	always_comb begin
		headStatus = statusQ.headData[RFH_REG_W-1:0];
		headStatus[RFH_B_VALID] = headValid;
		if (!headValid) begin
			headStatus = RFH_ZERO16;
		end
	end

	// Upper four bits of the count word are reserved and read zero.
	assign headCount = headValid ? {4'h0, statusQ.headData[RFH_ENTRY_W-1:RFH_REG_W]} :
		RFH_ZERO16;

	// ----------------------------------------------------------------
	// Host read decode
	// ----------------------------------------------------------------
	logic [7:0] wordAddr;
	logic hiByte;
	logic hitStatus;
	logic hitCount;
	logic countLowRead;
	logic countHighRead;
	logic [15:0] wordData;
	logic [15:0] readData;

	// In 16-bit mode the address low bit is ignored; in 8-bit mode it picks the byte.
	assign wordAddr = hostAddr & ~RFH_OFS_HI;
	assign hiByte = hostByteMode && hostAddr[0];
	assign hitStatus = wordAddr == RFH_OFS_STATUS;
	assign hitCount = wordAddr == RFH_OFS_COUNT;
	assign countLowRead = hostRd && hostByteMode && hitCount && !hiByte;
	assign countHighRead = hostRd && hostByteMode && hitCount && hiByte;

	// Unmapped offsets read as zero.
	assign wordData = hitStatus ? headStatus : (hitCount ? headCount : RFH_ZERO16);

	// The high count byte comes from the snapshot taken at the low byte read.
	// This keeps the two halves of one count together even if the head moves
	// between the two reads, at the cost of a stale byte if the order is broken.
	logic [7:0] countHiSnap_q;
	logic [7:0] countHiSnap_d;

	assign countHiSnap_d = countLowRead ? headCount[15:8] : countHiSnap_q;

	always_comb begin
		readData = wordData;
		if (hostByteMode) begin
			readData = {RFH_ZERO8, pickByte(wordData, hiByte)};
			if (countHighRead) begin
				readData = {RFH_ZERO8, countHiSnap_q};
			end
		end
	end

	// ----------------------------------------------------------------
	// Host read answer
	// ----------------------------------------------------------------
	rfh_rd_state_t rdState_q;
	rfh_rd_state_t rdState_d;
	logic [15:0] hostRdData_d;

	// Every read is answered one cycle after it is taken, back to back allowed.
	always_comb begin
		rdState_d = rdState_q;
		unique case (rdState_q)
			RFH_IDLE: begin
				if (hostRd) begin
					rdState_d = RFH_ANSWER;
				end
			end
			RFH_ANSWER: begin
				if (!hostRd) begin
					rdState_d = RFH_IDLE;
				end
			end
		endcase
	end

	// Data holds its last value between reads so a slow host can sample it.
	assign hostRdData_d = hostRd ? readData : hostRdData;

	// Short register bank for the read port.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdState_q <= RFH_IDLE;
			hostRdData <= RFH_ZERO16;
			countHiSnap_q <= RFH_ZERO8;
		end else begin
			rdState_q <= rdState_d;
			hostRdData <= hostRdData_d;
			countHiSnap_q <= countHiSnap_d;
		end
	end

	// Answer strobe marks the cycle after each taken read.
	assign hostRdValid = rdState_q == RFH_ANSWER;

	// ----------------------------------------------------------------
	// Side outputs
	// ----------------------------------------------------------------
	logic frameDropped_d;
	logic queueOverflow_d;

	// Reading the registers never pops; the host is expected to read once per
	// counted frame and release it, so extra reads just repeat the head.
	assign frameValid = headValid;
	assign framesQueued = statusQ.level;

	// Drops from filtering and from a full queue are reported apart.
	assign frameDropped_d = rxEnd && !acceptFrame;
	assign queueOverflow_d = rxEnd && acceptFrame && statusQ.full;

	// One-cycle event pulses registered so they are glitch free at the pins.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			frameDropped <= 1'b0;
			queueOverflow <= 1'b0;
		end else begin
			frameDropped <= frameDropped_d;
			queueOverflow <= queueOverflow_d;
		end
	end
endmodule : rfh_header_status

// ===== rtl/rfh_pkg.sv
// Constants, field positions and register offsets of the receive frame header status block.
// Assumes a byte-addressed host bus whose registers sit at the printed byte offsets.
package rfh_pkg;
	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] RFH_OFS_STATUS = 8'h7c;
	localparam logic [7:0] RFH_OFS_COUNT = 8'h7e;

	// ----------------------------------------------------------------
	// Status field positions
	// ----------------------------------------------------------------
	localparam int RFH_B_VALID = 15;
	localparam int RFH_B_ICMP = 13;
	localparam int RFH_B_IP = 12;
	localparam int RFH_B_TCP = 11;
	localparam int RFH_B_UDP = 10;
	localparam int RFH_B_BCAST = 7;
	localparam int RFH_B_MCAST = 6;
	localparam int RFH_B_UCAST = 5;
	localparam int RFH_B_SYMERR = 4;
	localparam int RFH_B_ETHTYPE = 3;
	localparam int RFH_B_OVERSIZE = 2;
	localparam int RFH_B_RUNT = 1;
	localparam int RFH_B_CRC = 0;

	// ----------------------------------------------------------------
	// Widths, thresholds and reset values
	// ----------------------------------------------------------------
	localparam int RFH_REG_W = 16;
	localparam int RFH_COUNT_W = 12;
	localparam int RFH_ENTRY_W = RFH_REG_W + RFH_COUNT_W;
	localparam int RFH_ADDR_W = 48;
	localparam int RFH_GROUP_BIT = 40;
	localparam logic [15:0] RFH_LEN_TYPE_MAX = 16'h05dc;
	localparam logic [11:0] RFH_OVERSIZE_MAX = 12'h7d0;
	localparam logic [15:0] RFH_ZERO16 = 16'h0000;
	localparam logic [7:0] RFH_ZERO8 = 8'h00;
	localparam logic [7:0] RFH_OFS_HI = 8'h01;
	localparam logic [47:0] RFH_BCAST_ADDR = 48'hffffffffffff;

	// Host read phases.
	typedef enum logic [1:0] {
		RFH_IDLE,
		RFH_ANSWER
	} rfh_rd_state_t;
endpackage : rfh_pkg

// ===== rtl/rfh_queue_if.sv
// Carrier between the frame status queue and the header status logic.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface rfh_queue_if #(
	parameter int WIDTH = 28,
	parameter int LEVEL_W = 4
);
	logic push;
	logic [WIDTH-1:0] pushData;
	logic full;
	logic pop;
	logic [WIDTH-1:0] headData;
	logic empty;
	logic [LEVEL_W-1:0] level;

	modport store (
		input push,
		input pushData,
		output full,
		input pop,
		output headData,
		output empty,
		output level
	);
	modport user (
		output push,
		output pushData,
		input full,
		output pop,
		input headData,
		input empty,
		input level
	);
endinterface : rfh_queue_if

// ===== rtl/rfh_status_queue.sv
// Queue of per-frame status and byte count entries, oldest entry at the head.
// Assumes the user never pushes when full nor pops when empty.
`timescale 1ns/1ps
module rfh_status_queue #(
	parameter int DEPTH = 8,
	parameter int PTR_W = 3
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	rfh_queue_if.store q
);
	logic [$bits(q.pushData)-1:0] mem [DEPTH];
	logic [PTR_W-1:0] wrPtr_q;
	logic [PTR_W-1:0] rdPtr_q;
	logic [PTR_W:0] level_q;
	logic doPush;
	logic doPop;

	// ----------------------------------------------------------------
	// Flow
	// ----------------------------------------------------------------
	// Guarded strobes keep the pointers honest even if a user slips.
	assign doPush = q.push && !q.full;
	assign doPop = q.pop && !q.empty;
	assign q.full = (level_q == (PTR_W + 1)'(DEPTH));
	assign q.empty = (level_q == '0);
	assign q.headData = mem[rdPtr_q];
	assign q.level = $bits(q.level)'(level_q);

	// Storage has no reset; the head is only read while not empty.
	always_ff @(posedge ref_clk) begin
		if (doPush) begin
			mem[wrPtr_q] <= q.pushData;
		end
	end

	// Pointers wrap at DEPTH so a non-power-of-two depth also works.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			level_q <= '0;
		end else begin
			if (doPush) begin
				wrPtr_q <= (wrPtr_q == PTR_W'(DEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
			end
			if (doPop) begin
				rdPtr_q <= (rdPtr_q == PTR_W'(DEPTH - 1)) ? '0 : rdPtr_q + 1'b1;
			end
			level_q <= level_q + (PTR_W + 1)'(doPush) - (PTR_W + 1)'(doPop);
		end
	end
endmodule : rfh_status_queue

// ===== testbench/rfh_header_status_props.sv
// Port-level checks on the receive frame header status block.
// Assumes one clock ref_clk and the asynchronous active-low reset rst_n.
`timescale 1ns/1ps
module rfh_header_status_props
	import rfh_pkg::*;
#(
	parameter int QUEUE_DEPTH = 8,
	parameter int QUEUE_PTR_W = 3
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic rxEnd,
	input wire logic [RFH_COUNT_W-1:0] rxByteCount,
	input wire logic rxCollision,
	input wire logic rxEarlyEnd,
	input wire logic rxCrcBad,
	input wire logic passBadFrame,
	input wire logic frameRelease,
	input wire logic hostByteMode,
	input wire logic hostRd,
	input wire logic [7:0] hostAddr,
	input wire logic [15:0] hostRdData,
	input wire logic hostRdValid,
	input wire logic frameValid,
	input wire logic [QUEUE_PTR_W:0] framesQueued,
	input wire logic frameDropped
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	logic stsRd_q;
	logic cntRd_q;
	logic fvAtRd_q;

	// Remember what kind of word read was taken, so its answer can be judged a cycle later.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			stsRd_q <= 1'b0;
			cntRd_q <= 1'b0;
			fvAtRd_q <= 1'b0;
		end else begin
			stsRd_q <= hostRd && !hostByteMode && hostAddr[7:1] == RFH_OFS_STATUS[7:1];
			cntRd_q <= hostRd && !hostByteMode && hostAddr[7:1] == RFH_OFS_COUNT[7:1];
			fvAtRd_q <= frameValid;
		end
	end

	property p_valid_bit;
		stsRd_q |-> hostRdData[RFH_B_VALID] == fvAtRd_q;
	endproperty
	a_valid_bit: assert property (p_valid_bit) else $error("valid bit wrong");
	property p_empty_word;
		stsRd_q && !fvAtRd_q |-> hostRdData == RFH_ZERO16;
	endproperty
	a_empty_word: assert property (p_empty_word) else $error("empty status not zero");
	property p_mcast;
		stsRd_q && hostRdData[RFH_B_BCAST] |-> hostRdData[RFH_B_MCAST];
	endproperty
	a_mcast: assert property (p_mcast) else $error("broadcast without multicast");
	property p_cnt_rsv;
		cntRd_q |-> hostRdData[15:12] == 4'h0;
	endproperty
	a_cnt_rsv: assert property (p_cnt_rsv) else $error("count upper bits set");
	property p_byte_hi;
		hostRdValid && $past(hostByteMode) |-> hostRdData[15:8] == RFH_ZERO8;
	endproperty
	a_byte_hi: assert property (p_byte_hi) else $error("byte read upper lane set");
	property p_drop_ovs;
		rxEnd && !passBadFrame && rxByteCount > RFH_OVERSIZE_MAX |=> frameDropped;
	endproperty
	a_drop_ovs: assert property (p_drop_ovs) else $error("oversize not dropped");
	property p_drop_runt;
		rxEnd && !passBadFrame && (rxCollision || rxEarlyEnd) |=> frameDropped;
	endproperty
	a_drop_runt: assert property (p_drop_runt) else $error("runt not dropped");
	property p_drop_crc;
		rxEnd && !passBadFrame && rxCrcBad |=> frameDropped;
	endproperty
	a_drop_crc: assert property (p_drop_crc) else $error("crc frame not dropped");
	property p_keep;
		rxEnd && passBadFrame && !frameRelease && framesQueued < QUEUE_DEPTH
			|=> framesQueued == $past(framesQueued) + 1'b1;
	endproperty
	a_keep: assert property (p_keep) else $error("passed frame not queued");
endmodule : rfh_header_status_props

bind rfh_header_status rfh_header_status_props #(.QUEUE_DEPTH(QUEUE_DEPTH),
	.QUEUE_PTR_W(QUEUE_PTR_W)) i_rfh_header_status_props (.ref_clk(ref_clk), .rst_n(rst_n),
	.rxEnd(rxEnd), .rxByteCount(rxByteCount), .rxCollision(rxCollision),
	.rxEarlyEnd(rxEarlyEnd), .rxCrcBad(rxCrcBad), .passBadFrame(passBadFrame),
	.frameRelease(frameRelease), .hostByteMode(hostByteMode), .hostRd(hostRd),
	.hostAddr(hostAddr), .hostRdData(hostRdData), .hostRdValid(hostRdValid),
	.frameValid(frameValid), .framesQueued(framesQueued), .frameDropped(frameDropped));

// ===== testbench/rfh_host_model.sv
// Host processor model that reads the header registers over the parallel port.
// Assumes the device answers each read strobe within a few cycles.
`timescale 1ns/1ps
module rfh_host_model (
	input wire logic ref_clk,
	output logic hostRd,
	output logic [7:0] hostAddr,
	output logic hostByteMode,
	input wire logic hostRdValid,
	input wire logic [15:0] hostRdData
);
	initial begin
		hostRd = 1'b0;
		hostAddr = 8'h00;
		hostByteMode = 1'b0;
	end

	// One read, issued whether or not the caller has a counted frame to read; a slow host
	// waits gap cycles first. The address is scrambled afterwards so nothing leans on it.
	task automatic readReg(input logic [7:0] a, input logic m, input int gap,
		output logic [15:0] d, output logic ok);
		int i;
		repeat (gap) @(posedge ref_clk);
		@(posedge ref_clk);
		#1;
		hostByteMode = m;
		hostAddr = a;
		hostRd = 1'b1;
		@(posedge ref_clk);
		#1;
		hostRd = 1'b0;
		hostAddr = ~a;
		ok = 1'b0;
		d = 16'h0000;
		for (i = 0; i < 4; i++) begin
			if (!ok && hostRdValid === 1'b1) begin
				d = hostRdData;
				ok = 1'b1;
			end
			if (!ok) begin
				@(posedge ref_clk);
				#1;
			end
		end
	endtask : readReg
endmodule : rfh_host_model

// ===== testbench/rx_frame_header_status_bench.sv
// Self-checking bench for the receive frame header status block.
// Assumes the host model and the bound checker from this folder.
`timescale 1ns/1ps
`define RFH_CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin error_cnt++; \
	$display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module rx_frame_header_status_bench;
	logic ref_clk;
	logic rst_n;
	logic rxEnd;
	logic [47:0] rxDestAddr;
	logic [15:0] rxLenType;
	logic [11:0] rxByteCount;
	logic [7:0] errs;
	logic passBadFrame;
	logic frameRelease;
	logic hostByteMode;
	logic hostRd;
	logic [7:0] hostAddr;
	logic [15:0] hostRdData;
	logic hostRdValid;
	logic frameValid;
	logic [3:0] framesQueued;
	logic frameDropped;
	logic queueOverflow;
	int error_cnt = 0;
	int comparisons = 0;

	// Error flags travel as one vector: symbol, collision, early end, crc, icmp, ip, tcp, udp.
	rfh_header_status #(.QUEUE_DEPTH(8), .QUEUE_PTR_W(3)) i_rfh_header_status (
		.ref_clk(ref_clk), .rst_n(rst_n), .rxEnd(rxEnd), .rxDestAddr(rxDestAddr),
		.rxLenType(rxLenType), .rxByteCount(rxByteCount), .rxSymbolErr(errs[7]),
		.rxCollision(errs[6]), .rxEarlyEnd(errs[5]), .rxCrcBad(errs[4]), .rxIcmpBad(errs[3]),
		.rxIpBad(errs[2]), .rxTcpBad(errs[1]), .rxUdpBad(errs[0]), .passBadFrame(passBadFrame),
		.frameRelease(frameRelease), .hostByteMode(hostByteMode), .hostRd(hostRd),
		.hostAddr(hostAddr), .hostRdData(hostRdData), .hostRdValid(hostRdValid),
		.frameValid(frameValid), .framesQueued(framesQueued), .frameDropped(frameDropped),
		.queueOverflow(queueOverflow)
	);
	rfh_host_model i_rfh_host_model (.ref_clk(ref_clk), .hostRd(hostRd), .hostAddr(hostAddr),
		.hostByteMode(hostByteMode), .hostRdValid(hostRdValid), .hostRdData(hostRdData));

	// Free-running 20 MHz clock.
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	task automatic conclude();
		if (error_cnt == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : conclude

	// A lost answer would stall every later scenario, so it ends the run.
	task automatic rdChk(input logic [7:0] a, input logic m, input int g, input logic [15:0] e);
		logic [15:0] d;
		logic ok;
		i_rfh_host_model.readReg(a, m, g, d, ok);
		if (ok !== 1'b1) begin
			error_cnt++;
			$display("mismatch at %0t: read timed out", $time);
			conclude();
		end else begin
			`RFH_CHK(d, e)
		end
	endtask : rdChk

	// The released address and error lines are inverted so a stale value cannot pass for a held one.
	task automatic sendFrame(input logic [47:0] d, input logic [15:0] t, input logic [11:0] c,
		input logic [7:0] e);
		@(posedge ref_clk);
		#1;
		rxDestAddr = d;
		rxLenType = t;
		rxByteCount = c;
		errs = e;
		rxEnd = 1'b1;
		@(posedge ref_clk);
		#1;
		rxEnd = 1'b0;
		rxDestAddr = ~d;
		errs = ~e;
	endtask : sendFrame

	task automatic releaseHead();
		@(posedge ref_clk);
		#1;
		frameRelease = 1'b1;
		@(posedge ref_clk);
		#1;
		frameRelease = 1'b0;
	endtask : releaseHead

	task automatic tEmpty();
		rdChk(8'h7c, 1'b0, 0, 16'h0000);
		rdChk(8'h7e, 1'b0, 2, 16'h0000);
		`RFH_CHK(frameValid, 1'b0)
	endtask : tEmpty

	task automatic tFlags();
		passBadFrame = 1'b1;
		sendFrame(48'hffffffffffff, 16'h05dd, 12'h7d1, 8'h08);
		sendFrame(48'h020000000001, 16'h05dc, 12'h7d0, 8'hd7);
		sendFrame(48'h010000000000, 16'h0040, 12'h040, 8'h20);
		`RFH_CHK(framesQueued, 4'h3)
		rdChk(8'h7c, 1'b0, 0, 16'ha0cc);
		rdChk(8'h7e, 1'b0, 3, 16'h07d1);
		releaseHead();
		rdChk(8'h7c, 1'b0, 0, 16'h9c33);
		rdChk(8'h7e, 1'b0, 0, 16'h07d0);
		releaseHead();
		rdChk(8'h7c, 1'b0, 0, 16'h8042);
		rdChk(8'h7e, 1'b0, 0, 16'h0040);
		releaseHead();
		rdChk(8'h7c, 1'b0, 0, 16'h0000);
	endtask : tFlags

	task automatic tDrop();
		passBadFrame = 1'b0;
		sendFrame(48'h0a0000000000, 16'h0800, 12'h7d1, 8'h00);
		`RFH_CHK(frameDropped, 1'b1)
		sendFrame(48'h0a0000000000, 16'h0800, 12'h040, 8'h40);
		`RFH_CHK(frameDropped, 1'b1)
		sendFrame(48'h0a0000000000, 16'h0800, 12'h040, 8'h10);
		`RFH_CHK(frameDropped, 1'b1)
		sendFrame(48'h0a0000000000, 16'h0800, 12'h7d0, 8'h00);
		`RFH_CHK(frameDropped, 1'b0)
		`RFH_CHK(framesQueued, 4'h1)
		rdChk(8'h7c, 1'b0, 0, 16'h8028);
		rdChk(8'h7c, 1'b1, 0, 16'h0028);
		rdChk(8'h7d, 1'b1, 0, 16'h0080);
		rdChk(8'h7e, 1'b1, 0, 16'h00d0);
		rdChk(8'h7f, 1'b1, 1, 16'h0007);
		rdChk(8'h7a, 1'b0, 0, 16'h0000);
		releaseHead();
	endtask : tDrop

	// Fills the queue, then one more accepted frame must be refused with an overflow pulse.
	task automatic tOverflow();
		passBadFrame = 1'b1;
		repeat (8) sendFrame(48'h0a0000000000, 16'h0800, 12'h040, 8'h00);
		`RFH_CHK(framesQueued, 4'h8)
		`RFH_CHK(queueOverflow, 1'b0)
		sendFrame(48'h0a0000000000, 16'h0800, 12'h041, 8'h00);
		`RFH_CHK(queueOverflow, 1'b1)
		`RFH_CHK(framesQueued, 4'h8)
		repeat (8) releaseHead();
		`RFH_CHK(frameValid, 1'b0)
	endtask : tOverflow

	// Main sequence: all inputs defined at time zero, reset for three cycles.
	initial begin
		rst_n = 1'b0;
		rxEnd = 1'b0;
		rxDestAddr = 48'h000000000000;
		rxLenType = 16'h0000;
		rxByteCount = 12'h000;
		errs = 8'h00;
		passBadFrame = 1'b0;
		frameRelease = 1'b0;
		repeat (3) @(posedge ref_clk);
		#1;
		rst_n = 1'b1;
		tEmpty();
		tFlags();
		tDrop();
		tOverflow();
		conclude();
	end

	// Overall limit in case a wait inside the design never ends.
	initial begin
		#1000000;
		error_cnt++;
		$display("mismatch at %0t: run limit reached", $time);
		conclude();
	end
endmodule : rx_frame_header_status_bench
